// ### pkg/scg_regs.vh
/*
  Register map, field positions, reset values and masks of the system clock and
  peripheral gating block. Assumes byte addressing on a 32-bit AXI4-Lite bus.
*/
// Operation
// - Peripheral held in reset only while its enable bit is zero
// - Enables reset to one; zero returns to reset
// - Enable two: ADCs 21/20, PWM 16, UARTs, I2C, SPI
// - Peripheral clock runs only after enable written one
// - Writing zero stops that peripheral clock
// - Clock gate one layout; bits 3:0 reserved read-only
// - Clock gate two layout matches enable two
// - Ring oscillator field 5:4, reset 10
// - Crystal oscillator field 1:0: stop, run, halve
// - Bit 2 picks internal or crystal PLL input
// - Main clock: ring, bypassed PLL input, PLL output
// - Bit 15 zero: failure forces ring oscillator
// - Bit 7 monitor enable resets one; bit 6 irq enable
// - Bit 5 main failure pending, write one clears
// - Bit 4 shows main clock presence
// - Bit 3 crystal monitor enable, bit 2 irq enable
// - Bit 1 crystal failure pending, write one clears
// - Bit 0 shows crystal oscillating normally
// - Configuration write needs key in bits 31:16
// - Five sticky non-maskable source flags
// - Flag raises non-maskable only when enabled
// - Enables: protection 4 down to brown-out 0
`ifndef SCG_REGS_VH
`define SCG_REGS_VH

// Byte addresses
`define SCG_ADDR_PERIPH_ENABLE_ONE 32'h4000_0028
`define SCG_ADDR_PERIPH_ENABLE_TWO 32'h4000_002C
`define SCG_ADDR_CG1 32'h4000_0030
`define SCG_ADDR_CG2 32'h4000_0034
`define SCG_ADDR_OSC 32'h4000_0040
`define SCG_ADDR_SCS 32'h4000_0044
`define SCG_ADDR_CMON 32'h4000_0048
`define SCG_ADDR_NMI 32'h4000_004C

// Decoded register indices
`define SCG_IDX_NONE 4'h0
`define SCG_IDX_PERIPH_ENABLE_ONE 4'h1
`define SCG_IDX_PERIPH_ENABLE_TWO 4'h2
`define SCG_IDX_CG1 4'h3
`define SCG_IDX_CG2 4'h4
`define SCG_IDX_OSC 4'h5
`define SCG_IDX_SCS 4'h6
`define SCG_IDX_CMON 4'h7
`define SCG_IDX_NMI 4'h8

// Implemented bits of the enable and clock gate registers
`define SCG_MASK_ONE 32'h030F_0F10
`define SCG_MASK_TWO 32'h0031_0311
`define SCG_CG1_RSVD 32'h0000_000F

// Oscillator and clock select fields
`define SCG_RING_LSB 4
`define SCG_XTAL_LSB 0
`define SCG_RING_RST 2'h2
`define SCG_XTAL_RST 2'h0
`define SCG_PLLSEL_BIT 2
`define SCG_MSEL_RING 2'h0

// Clock monitor bits
`define SCG_CM_RECOVER 15
`define SCG_CM_MMON 7
`define SCG_CM_MIE 6
`define SCG_CM_MPEND 5
`define SCG_CM_MSTS 4
`define SCG_CM_XMON 3
`define SCG_CM_XIE 2
`define SCG_CM_XPEND 1
`define SCG_CM_XSTS 0

// Non-maskable configuration
`define SCG_NMI_KEY 16'hA32C
`define SCG_NMI_FLAG_LSB 8
`define SCG_NMI_EN_RST 5'h01

// Bus responses
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_SLVERR 2'h2

`endif

// ### verilog/scg_top.v
/*
  System clock and peripheral gating: peripheral reset holds, clock gates,
  oscillator and clock source selection, clock failure monitors and the
  non-maskable source collector, all behind an AXI4-Lite slave.
  Assumes all inputs are synchronous to mclk_in and that the failure
  detectors deliver a plain level meaning "clock alive".
*/
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "scg_regs.vh"

module scg_top
(
  // Clock and reset
  input wire mclk_in,
  input wire reset_in,
  // AXI4-Lite write address and data
  input wire axi_awvalid_in,
  output wire axi_awready_out,
  input wire [31:0] axi_awaddr_in,
  input wire [2:0] axi_awprot_in,
  input wire axi_wvalid_in,
  output wire axi_wready_out,
  input wire [31:0] axi_wdata_in,
  input wire [3:0] axi_wstrb_in,
  // AXI4-Lite write response
  output reg axi_bvalid_out,
  input wire axi_bready_in,
  output reg [1:0] axi_bresp_out,
  // AXI4-Lite read
  input wire axi_arvalid_in,
  output wire axi_arready_out,
  input wire [31:0] axi_araddr_in,
  input wire [2:0] axi_arprot_in,
  output reg axi_rvalid_out,
  input wire axi_rready_in,
  output reg [31:0] axi_rdata_out,
  output reg [1:0] axi_rresp_out,
  // Clock detectors
  input wire main_clock_alive_in,
  input wire crystal_alive_in,
  // Non-maskable event sources
  input wire protection_event_in,
  input wire overvoltage_event_in,
  input wire watchdog_event_in,
  input wire brownout_event_in,
  // Peripheral resets and clock gates
  output wire [31:0] periph_reset_one_out,
  output wire [31:0] periph_reset_two_out,
  output wire [31:0] clock_gate_one_out,
  output wire [31:0] clock_gate_two_out,
  // Oscillator and clock source control
  output wire ring_osc_run_out,
  output wire ring_osc_div2_out,
  output wire crystal_osc_run_out,
  output wire crystal_osc_div2_out,
  output wire pll_input_select_out,
  output wire [1:0] main_clock_select_out,
  // Interrupt requests
  output wire main_clock_fail_irq_out,
  output wire crystal_fail_irq_out,
  output wire nmi_out
);

  // Address decode, shared by the write and read paths
  function [3:0] scg_decode;
    input [31:0] addr;
    begin
      case ({addr[31:2], 2'h0})
        `SCG_ADDR_PERIPH_ENABLE_ONE: scg_decode = `SCG_IDX_PERIPH_ENABLE_ONE;
        `SCG_ADDR_PERIPH_ENABLE_TWO: scg_decode = `SCG_IDX_PERIPH_ENABLE_TWO;
        `SCG_ADDR_CG1: scg_decode = `SCG_IDX_CG1;
        `SCG_ADDR_CG2: scg_decode = `SCG_IDX_CG2;
        `SCG_ADDR_OSC: scg_decode = `SCG_IDX_OSC;
        `SCG_ADDR_SCS: scg_decode = `SCG_IDX_SCS;
        `SCG_ADDR_CMON: scg_decode = `SCG_IDX_CMON;
        `SCG_ADDR_NMI: scg_decode = `SCG_IDX_NMI;
        default: scg_decode = `SCG_IDX_NONE;
      endcase
    end
  endfunction

  // Byte-lane merge of write data into an old register value
  function [31:0] scg_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] strb;
    integer i;
    begin
      scg_merge = old;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (strb[i])
        begin
          scg_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  // Control registers
  reg [31:0] periph_enable_one;
  reg [31:0] periph_enable_two;
  reg [31:0] clock_gate_one;
  reg [31:0] clock_gate_two;
  reg [1:0] ring_osc_ctrl;
  reg [1:0] crystal_osc_ctrl;
  reg pll_input_select;
  reg [1:0] main_clock_select;
  reg main_clock_auto_recover;
  reg main_clock_monitor_en;
  reg main_clock_fail_irq_en;
  reg main_clock_fail_pending;
  reg crystal_monitor_en;
  reg crystal_fail_irq_en;
  reg crystal_fail_pending;
  reg [4:0] nmi_flags;
  reg [4:0] nmi_enables;

  // Bus slave state
  reg aw_full;
  reg w_full;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire do_write;
  wire [3:0] wr_idx;
  wire [31:0] merged;
  wire key_ok;
  wire mclk_fail_evt;
  wire xtal_fail_evt;
  wire [4:0] nmi_events;
  wire [31:0] cmon_view;
  wire [31:0] nmi_view;
  wire [287:0] all_views;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  // One write at a time: address and data are parked until the response is taken
  assign axi_awready_out = ~aw_full & ~axi_bvalid_out;
  assign axi_wready_out = ~w_full & ~axi_bvalid_out;
  assign axi_arready_out = ~axi_rvalid_out;
  assign do_write = aw_full & w_full & ~axi_bvalid_out;
  assign wr_idx = scg_decode(aw_addr);

  // Merge against the register's current view so unwritten lanes keep their value
  assign merged = scg_merge(next_rdata_w(wr_idx, all_views), w_data, w_strb);
  assign key_ok = (w_strb[3:2] == 2'h3) && (w_data[31:16] == `SCG_NMI_KEY);

  // Failure detection only while the monitor is switched on
  assign mclk_fail_evt = main_clock_monitor_en & ~main_clock_alive_in;
  assign xtal_fail_evt = crystal_monitor_en & crystal_osc_ctrl[1] & ~crystal_alive_in;

  // Non-maskable sources: protection, over-voltage, watchdog, clock fail, brown-out
  assign nmi_events = {protection_event_in, overvoltage_event_in, watchdog_event_in,
                       mclk_fail_evt, brownout_event_in};

  assign cmon_view = {16'h0000, main_clock_auto_recover, 7'h00,
                      main_clock_monitor_en, main_clock_fail_irq_en,
                      main_clock_fail_pending, main_clock_alive_in,
                      crystal_monitor_en, crystal_fail_irq_en,
                      crystal_fail_pending, crystal_alive_in};
  assign nmi_view = {16'h0000, 3'h0, nmi_flags, 3'h0, nmi_enables};

  // Views packed by index, slot 0 unmapped; handing them to the lookup as an argument
  // keeps every caller sensitive to register changes, which a hidden reference would not
  assign all_views = {nmi_view, cmon_view, {29'h0, pll_input_select, main_clock_select},
                      {26'h0, ring_osc_ctrl, 2'h0, crystal_osc_ctrl}, clock_gate_two,
                      clock_gate_one | `SCG_CG1_RSVD, periph_enable_two,
                      periph_enable_one, 32'h0000_0000};

  // Register view by index; the key field reads as zero
  function [31:0] next_rdata_w;
    input [3:0] idx;
    input [287:0] views;
    begin
      if (idx <= `SCG_IDX_NMI)
        next_rdata_w = views[idx*32 +: 32];
      else
        next_rdata_w = 32'h0000_0000;
    end
  endfunction

  // Read answer for the address being offered
  always @*
  begin
    next_rdata = next_rdata_w(scg_decode(axi_araddr_in), all_views);
    if (scg_decode(axi_araddr_in) == `SCG_IDX_NONE)
    begin
      next_rresp = `SCG_RESP_SLVERR;
    end
    else
    begin
      next_rresp = `SCG_RESP_OKAY;
    end
  end

  // Write channel capture and response
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      axi_bvalid_out <= 1'b0;
      axi_bresp_out <= `SCG_RESP_OKAY;
    end
    else
    begin
      if (axi_awvalid_in && axi_awready_out)
      begin
        aw_full <= 1'b1;
        aw_addr <= axi_awaddr_in;
      end
      if (axi_wvalid_in && axi_wready_out)
      begin
        w_full <= 1'b1;
        w_data <= axi_wdata_in;
        w_strb <= axi_wstrb_in;
      end
      if (do_write)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        axi_bvalid_out <= 1'b1;
        axi_bresp_out <= (wr_idx == `SCG_IDX_NONE) ? `SCG_RESP_SLVERR : `SCG_RESP_OKAY;
      end
      else if (axi_bvalid_out && axi_bready_in)
      begin
        axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      axi_rvalid_out <= 1'b0;
      axi_rdata_out <= 32'h0000_0000;
      axi_rresp_out <= `SCG_RESP_OKAY;
    end
    else if (axi_arvalid_in && axi_arready_out)
    begin
      axi_rvalid_out <= 1'b1;
      axi_rdata_out <= next_rdata;
      axi_rresp_out <= next_rresp;
    end
    else if (axi_rvalid_out && axi_rready_in)
    begin
      axi_rvalid_out <= 1'b0;
    end
  end

  // Peripheral enables and clock gates; unimplemented bits stay zero
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      periph_enable_one <= `SCG_MASK_ONE;
      periph_enable_two <= `SCG_MASK_TWO;
      clock_gate_one <= 32'h0000_0000;
      clock_gate_two <= 32'h0000_0000;
    end
    else if (do_write)
    begin
      case (wr_idx)
        `SCG_IDX_PERIPH_ENABLE_ONE: periph_enable_one <= merged & `SCG_MASK_ONE;
        `SCG_IDX_PERIPH_ENABLE_TWO: periph_enable_two <= merged & `SCG_MASK_TWO;
        `SCG_IDX_CG1: clock_gate_one <= merged & `SCG_MASK_ONE;
        `SCG_IDX_CG2: clock_gate_two <= merged & `SCG_MASK_TWO;
        default: ;
      endcase
    end
  end

  // Oscillator control and clock source selection
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      ring_osc_ctrl <= `SCG_RING_RST;
      crystal_osc_ctrl <= `SCG_XTAL_RST;
      pll_input_select <= 1'b0;
      main_clock_select <= `SCG_MSEL_RING;
    end
    else
    begin
      if (do_write && (wr_idx == `SCG_IDX_OSC))
      begin
        ring_osc_ctrl <= merged[`SCG_RING_LSB +: 2];
        crystal_osc_ctrl <= merged[`SCG_XTAL_LSB +: 2];
      end
      if (do_write && (wr_idx == `SCG_IDX_SCS))
      begin
        // Switching the PLL input is only safe with both oscillators alive
        pll_input_select <= merged[`SCG_PLLSEL_BIT];
        main_clock_select <= merged[1:0];
      end
      // Hardware fallback beats a simultaneous software write
      if (mclk_fail_evt && !main_clock_auto_recover)
      begin
        main_clock_select <= `SCG_MSEL_RING;
      end
    end
  end

  // Clock monitor control and sticky pending flags; a new failure beats the clear
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      main_clock_auto_recover <= 1'b0;
      main_clock_monitor_en <= 1'b1;
      main_clock_fail_irq_en <= 1'b0;
      main_clock_fail_pending <= 1'b0;
      crystal_monitor_en <= 1'b0;
      crystal_fail_irq_en <= 1'b0;
      crystal_fail_pending <= 1'b0;
    end
    else
    begin
      if (do_write && (wr_idx == `SCG_IDX_CMON))
      begin
        main_clock_auto_recover <= merged[`SCG_CM_RECOVER];
        main_clock_monitor_en <= merged[`SCG_CM_MMON];
        main_clock_fail_irq_en <= merged[`SCG_CM_MIE];
        crystal_monitor_en <= merged[`SCG_CM_XMON];
        crystal_fail_irq_en <= merged[`SCG_CM_XIE];
        if (w_data[`SCG_CM_MPEND] && w_strb[0])
        begin
          main_clock_fail_pending <= 1'b0;
        end
        if (w_data[`SCG_CM_XPEND] && w_strb[0])
        begin
          crystal_fail_pending <= 1'b0;
        end
      end
      if (mclk_fail_evt)
      begin
        main_clock_fail_pending <= 1'b1;
      end
      if (xtal_fail_evt)
      begin
        crystal_fail_pending <= 1'b1;
      end
    end
  end

  // Non-maskable configuration: keyed writes only; writing one clears a flag
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      nmi_flags <= 5'h00;
      nmi_enables <= `SCG_NMI_EN_RST;
    end
    else
    begin
      if (do_write && (wr_idx == `SCG_IDX_NMI) && key_ok)
      begin
        nmi_enables <= merged[4:0];
        nmi_flags <= (nmi_flags & ~w_data[`SCG_NMI_FLAG_LSB +: 5]) | nmi_events;
      end
      else
      begin
        nmi_flags <= nmi_flags | nmi_events;
      end
    end
  end

  // Outputs: reset holds are the inverse of enables on implemented bits
  assign periph_reset_one_out = ~periph_enable_one & `SCG_MASK_ONE;
  assign periph_reset_two_out = ~periph_enable_two & `SCG_MASK_TWO;
  assign clock_gate_one_out = clock_gate_one;
  assign clock_gate_two_out = clock_gate_two;
  assign ring_osc_run_out = ring_osc_ctrl[1];
  assign ring_osc_div2_out = ring_osc_ctrl[1] & ring_osc_ctrl[0];
  assign crystal_osc_run_out = crystal_osc_ctrl[1];
  assign crystal_osc_div2_out = crystal_osc_ctrl[1] & crystal_osc_ctrl[0];
  assign pll_input_select_out = pll_input_select;
  assign main_clock_select_out = main_clock_select;
  assign main_clock_fail_irq_out = main_clock_fail_pending & main_clock_fail_irq_en;
  assign crystal_fail_irq_out = crystal_fail_pending & crystal_fail_irq_en;
  assign nmi_out = |(nmi_flags & nmi_enables);

endmodule // scg_top

// ### tb/scg_top_properties.sv
/*
  Checker for scg_top: control outputs move only on completed writes or
  monitor events, and unimplemented bits of reset hold two and both gates stay low.
  Assumes the register header is on the include path.
*/
`timescale 1ns/1ps
`include "scg_regs.vh"

module scg_top_properties
(
  // Clock and reset
  input wire mclk_in,
  input wire reset_in,
  // Bus and detector inputs
  input wire axi_bvalid_out,
  input wire main_clock_alive_in,
  input wire crystal_alive_in,
  input wire protection_event_in,
  input wire overvoltage_event_in,
  input wire watchdog_event_in,
  input wire brownout_event_in,
  // Controls
  input wire [31:0] periph_reset_one_out,
  input wire [31:0] periph_reset_two_out,
  input wire [31:0] clock_gate_one_out,
  input wire [31:0] clock_gate_two_out,
  input wire ring_osc_run_out,
  input wire ring_osc_div2_out,
  input wire crystal_osc_run_out,
  input wire crystal_osc_div2_out,
  input wire pll_input_select_out,
  input wire [1:0] main_clock_select_out,
  // Requests
  input wire main_clock_fail_irq_out,
  input wire crystal_fail_irq_out,
  input wire nmi_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // Register-driven outputs change only with a write response
  property p_per;
    !$stable({periph_reset_one_out, periph_reset_two_out}) |-> $rose(axi_bvalid_out);
  endproperty
  a_per: assert property (p_per) else $error("reset hold moved without write");
  property p_gate;
    !$stable({clock_gate_one_out, clock_gate_two_out, pll_input_select_out})
      |-> $rose(axi_bvalid_out);
  endproperty
  a_gate: assert property (p_gate) else $error("gate moved without write");
  property p_two;
    (periph_reset_two_out & ~`SCG_MASK_TWO) == 32'h0;
  endproperty
  a_two: assert property (p_two) else $error("stray reset hold bit");
  property p_g1;
    (clock_gate_one_out & ~`SCG_MASK_ONE) == 32'h0;
  endproperty
  a_g1: assert property (p_g1) else $error("stray gate one bit");
  property p_g2;
    (clock_gate_two_out & ~`SCG_MASK_TWO) == 32'h0;
  endproperty
  a_g2: assert property (p_g2) else $error("stray gate two bit");
  // Halving implies running
  property p_ring;
    !$stable({ring_osc_run_out, ring_osc_div2_out})
      |-> $rose(axi_bvalid_out) && !(ring_osc_div2_out && !ring_osc_run_out);
  endproperty
  a_ring: assert property (p_ring) else $error("ring control wrong");
  property p_xtal;
    !$stable({crystal_osc_run_out, crystal_osc_div2_out})
      |-> $rose(axi_bvalid_out) && !(crystal_osc_div2_out && !crystal_osc_run_out);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal control wrong");
  // Recovery may force the ring source without a write
  property p_sel;
    !$stable(main_clock_select_out) |-> $rose(axi_bvalid_out)
      || (main_clock_select_out == 2'h0 && $past(!main_clock_alive_in));
  endproperty
  a_sel: assert property (p_sel) else $error("clock select moved");
  property p_mirq;
    $rose(main_clock_fail_irq_out) |-> $rose(axi_bvalid_out) || $past(!main_clock_alive_in);
  endproperty
  a_mirq: assert property (p_mirq) else $error("main irq without cause");
  property p_xirq;
    $rose(crystal_fail_irq_out) |-> $rose(axi_bvalid_out) || $past(!crystal_alive_in);
  endproperty
  a_xirq: assert property (p_xirq) else $error("crystal irq without cause");
  property p_nmi;
    $rose(nmi_out) |-> $rose(axi_bvalid_out) || $past(protection_event_in
      || overvoltage_event_in || watchdog_event_in || brownout_event_in || !main_clock_alive_in);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi without cause");
endmodule // scg_top_properties

bind scg_top scg_top_properties i_scg_top_properties (.*);

// ### tb/scg_top_tb.sv
/*
  Self-checking bench for scg_top over AXI4-Lite.
  Assumes the register header is on the include path.
*/
`timescale 1ns/1ps
`include "scg_regs.vh"

module scg_top_tb;
  reg clk, rst, awv, wv, arv, ma, xa, one;
  reg [31:0] aa, wd, ra, seed, d, q;
  reg [3:0] ev;
  reg [1:0] rsp;
  integer err_count, cmp_count, i, k;
  wire awr, wrd, bv, arr, rv, rrun, rdiv, xrun, xdiv, psel, mirq, xirq, nmi;
  wire [1:0] br, rr, msel;
  wire [31:0] rdt, pr1, pr2, cg1, cg2;

  scg_top i_scg_top
  (
    .mclk_in(clk), .reset_in(rst), .axi_awvalid_in(awv), .axi_awready_out(awr),
    .axi_awaddr_in(aa), .axi_awprot_in(3'h0), .axi_wvalid_in(wv), .axi_wready_out(wrd),
    .axi_wdata_in(wd), .axi_wstrb_in(4'hF), .axi_bvalid_out(bv), .axi_bready_in(one),
    .axi_bresp_out(br), .axi_arvalid_in(arv), .axi_arready_out(arr), .axi_araddr_in(ra),
    .axi_arprot_in(3'h0), .axi_rvalid_out(rv), .axi_rready_in(one), .axi_rdata_out(rdt),
    .axi_rresp_out(rr), .main_clock_alive_in(ma), .crystal_alive_in(xa),
    .protection_event_in(ev[3]), .overvoltage_event_in(ev[2]), .watchdog_event_in(ev[1]),
    .brownout_event_in(ev[0]), .periph_reset_one_out(pr1), .periph_reset_two_out(pr2),
    .clock_gate_one_out(cg1), .clock_gate_two_out(cg2), .ring_osc_run_out(rrun),
    .ring_osc_div2_out(rdiv), .crystal_osc_run_out(xrun), .crystal_osc_div2_out(xdiv),
    .pll_input_select_out(psel), .main_clock_select_out(msel),
    .main_clock_fail_irq_out(mirq), .crystal_fail_irq_out(xirq), .nmi_out(nmi)
  );

  // 125 MHz clock
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  // Write: both channels offered together, each dropped once taken
  task wr(input [31:0] a, input [31:0] v);
  begin
    aa <= a; wd <= v; awv <= 1; wv <= 1;
    @(posedge clk);
    while (bv !== 1'b1)
    begin
      if (awr === 1'b1) awv <= 0;
      if (wrd === 1'b1) wv <= 0;
      @(posedge clk);
    end
    rsp = br;
  end
  endtask

  // Read: result lands in q and rsp
  task rd(input [31:0] a);
  begin
    ra <= a; arv <= 1;
    @(posedge clk);
    while (rv !== 1'b1)
    begin
      if (arr === 1'b1) arv <= 0;
      @(posedge clk);
    end
    q = rdt;
    rsp = rr;
  end
  endtask

  task chk(input [31:0] s, input [31:0] e);
  begin
    cmp_count = cmp_count + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  end
  endtask

  // Enable and gate registers alternate between the two layouts
  function [31:0] gmask(input integer j);
    gmask = j[0] ? `SCG_MASK_TWO : `SCG_MASK_ONE;
  endfunction

  task wrap_up;
  begin
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // Watchdog well beyond the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count = err_count + 1;
    wrap_up;
  end

  initial
  begin
    err_count = 0; cmp_count = 0; seed = 32'h337A3A94; one = 1;
    rst = 1; awv = 0; wv = 0; arv = 0; aa = 0; wd = 0; ra = 0; ma = 1; xa = 1; ev = 0;
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    // Reset values
    rd(`SCG_ADDR_PERIPH_ENABLE_ONE); chk(q, 32'h030F_0F10);
    rd(`SCG_ADDR_PERIPH_ENABLE_TWO); chk(q, `SCG_MASK_TWO);
    rd(`SCG_ADDR_CG1); chk(q, 32'hF);
    rd(`SCG_ADDR_CG2); chk(q, 32'h0);
    rd(`SCG_ADDR_OSC); chk(q, 32'h20);
    rd(`SCG_ADDR_SCS); chk(q, 32'h0);
    rd(`SCG_ADDR_CMON); chk(q, 32'h91);
    rd(`SCG_ADDR_NMI); chk(q, 32'h1);
    chk(pr1 | pr2 | cg1 | cg2, 32'h0);
    // Random enables and gates, read-only low bits of gate one
    for (i = 0; i < 24; i = i + 1)
    begin
      k = i % 4;
      d = $random(seed);
      wr(32'h4000_0028 + 4 * k, d);
      rd(32'h4000_0028 + 4 * k);
      chk(q, (d & gmask(k)) | (k == 2 ? 32'hF : 32'h0));
      if (k < 2) chk(k ? pr2 : pr1, ~d & gmask(k));
      else chk(k == 3 ? cg2 : cg1, d & gmask(k));
    end
    // Every oscillator code
    for (i = 0; i < 16; i = i + 1)
    begin
      d = {26'h0, i[3:2], 2'h0, i[1:0]};
      wr(`SCG_ADDR_OSC, d);
      rd(`SCG_ADDR_OSC); chk(q, d);
      chk({rrun, rdiv, xrun, xdiv}, {i[3], i[3:2] == 2'h3, i[1], i[1:0] == 2'h3});
    end
    // Every source select code
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(`SCG_ADDR_SCS, i);
      rd(`SCG_ADDR_SCS); chk(q, i);
      chk({psel, msel}, i);
    end
    // Both monitors fire, recovery forces the ring source
    wr(`SCG_ADDR_OSC, 32'h22); wr(`SCG_ADDR_SCS, 3); wr(`SCG_ADDR_CMON, 32'hCC);
    ma <= 0; xa <= 0;
    @(posedge clk);
    ma <= 1; xa <= 1;
    repeat (2) @(posedge clk);
    chk({mirq, xirq, msel}, 4'hC);
    rd(`SCG_ADDR_CMON); chk(q, 32'hFF);
    wr(`SCG_ADDR_CMON, 32'h80EE); chk({mirq, xirq}, 0);
    // Recovery disabled: source kept, status shows the lost clock
    wr(`SCG_ADDR_SCS, 3);
    ma <= 0;
    @(posedge clk);
    rd(`SCG_ADDR_CMON); chk(q, 32'h80ED);
    ma <= 1;
    @(posedge clk);
    chk({mirq, msel}, 3'h7);
    wr(`SCG_ADDR_CMON, 32'h88); chk(mirq, 0);
    // Non-maskable flags, key and per-source enables
    rd(`SCG_ADDR_NMI); chk(q, 32'h201);
    chk(nmi, 0);
    wr(`SCG_ADDR_NMI, 32'h1F); rd(`SCG_ADDR_NMI); chk(q, 32'h201);
    for (i = 0; i < 4; i = i + 1)
    begin
      k = i ? i + 9 : 8;
      wr(`SCG_ADDR_NMI, 32'hA32C_1F00 | (32'h1F ^ (1 << (k - 8))));
      ev <= 1 << i;
      @(posedge clk);
      ev <= 0;
      @(posedge clk);
      chk(nmi, 0);
      rd(`SCG_ADDR_NMI); chk(q, (1 << k) | (32'h1F ^ (1 << (k - 8))));
      wr(`SCG_ADDR_NMI, 32'hA32C_001F); chk(nmi, 1);
    end
    // Unmapped address
    wr(32'h4000_0038, 32'hFFFF_FFFF); chk(rsp, `SCG_RESP_SLVERR);
    rd(32'h4000_0038);
    chk(rsp, `SCG_RESP_SLVERR);
    chk(q, 32'h0);
    wrap_up;
  end
endmodule // scg_top_tb
